// ==== design/carrier_pkg.sv ====
// Constants, bus bundles and reset values for the carrier decode block.
// Assumes a 10 MHz local clock and at most four 16-bit IP slots.
package carrier_pkg;

   // ****************************************
   // Address modifiers and decode layout
   // ****************************************
   localparam logic [5:0] AM_SIO_USER = 6'h29;
   localparam logic [5:0] AM_SIO_SUP  = 6'h2d;
   localparam logic [5:0] AM_STD_USER = 6'h39;
   localparam logic [5:0] AM_STD_SUP  = 6'h3d;
   localparam logic [9:0] STATUS_OFF  = 10'h000;
   localparam logic [9:0] CLEAR_OFF   = 10'h002;
   localparam logic [9:0] IO_LO       = 10'h100;
   localparam logic [9:0] ID_LO       = 10'h300;
   localparam logic [7:0] ID_UPPER    = 8'hff;
   localparam int         NSLOT       = 4;
   localparam int         NREQ        = 8;

   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned CLK_MHZ     = 10;
   localparam int unsigned LED_TIME_US = 100000;
   localparam int unsigned LED_CYCLES  = LED_TIME_US * CLK_MHZ;

   // ****************************************
   // Bundles
   // ****************************************
   typedef struct packed {
      logic [23:1] addr;
      logic [5:0]  am;
      logic        as_n;
      logic [1:0]  ds_n;
      logic        write_n;
      logic        iack_n;
      logic        iackin_n;
      logic [15:0] data;
   } vme_in_t;

   typedef struct packed {
      logic [15:0] data;
      logic        data_oe;
      logic        dtack_oe;
      logic        iackout_n;
   } vme_out_t;

   typedef struct packed {
      logic [3:0]  ack_n;
      logic [7:0]  intreq_n;
      logic [15:0] rdata;
   } ip_in_t;

   typedef struct packed {
      logic [3:0]  io_sel_n;
      logic [3:0]  id_sel_n;
      logic [3:0]  mem_sel_n;
      logic [3:0]  ip_interrupt_select_n;
      logic [22:1] addr;
      logic [1:0]  byte_n;
      logic        write_n;
      logic [15:0] wdata;
   } ip_out_t;

   typedef struct packed {
      logic [15:10]   sio_base;
      logic           mem_enable;
      logic [2:0]     irq_level;
      logic [3:0][3:0] mem_base;
      logic [3:0][1:0] mem_size;
   } cfg_t;

   localparam vme_in_t  VME_IN_IDLE  = '1;
   localparam vme_out_t VME_OUT_IDLE = '{data: 16'h0000, data_oe: 1'b0, dtack_oe: 1'b0,
                                         iackout_n: 1'b1};
   localparam ip_out_t  IP_OUT_IDLE  = '{io_sel_n: 4'hf, id_sel_n: 4'hf, mem_sel_n: 4'hf,
                                         ip_interrupt_select_n: 4'hf, addr: 22'h000000,
                                         byte_n: 2'h3, write_n: 1'b1, wdata: 16'h0000};

endpackage

// ==== design/vme_ip_carrier_slave_decode.sv ====
// Slave decode, interrupter and activity stretchers of an IP carrier.
// Assumes VME and IP pins arrive asynchronous; cfg comes from local logic.

module vme_ip_carrier_slave_decode #(
   parameter int unsigned led_cycles = carrier_pkg::LED_CYCLES
) (
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   input  carrier_pkg::vme_in_t      vme_in,
   output carrier_pkg::vme_out_t     vme_out,
   output logic [7:1]                irq_oe,
   input  carrier_pkg::ip_in_t       ip_in,
   output carrier_pkg::ip_out_t      ip_out,
   input  carrier_pkg::cfg_t         cfg,
   output logic [3:0]                led
);

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_HOLD = 2'b10
   } state_t;

   // ****************************************
   // Functions
   // ****************************************
   function automatic logic [2:0] first_req(input logic [7:0] req);
      logic [2:0] w;
      w = 3'h0;
      for (int k = carrier_pkg::NREQ - 1; k >= 0; k--)
      begin
         if (req[k])
            w = 3'(k);
      end
      return w;
   endfunction

   function automatic logic [3:0] size_mask(input logic [1:0] size);
      return 4'((4'h1 << size) - 4'h1);
   endfunction

   // ****************************************
   // Input synchronisers
   // ****************************************
   carrier_pkg::vme_in_t v_meta;
   carrier_pkg::vme_in_t v;
   carrier_pkg::ip_in_t  i_meta;
   carrier_pkg::ip_in_t  ip;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         v_meta <= carrier_pkg::VME_IN_IDLE;
         v      <= carrier_pkg::VME_IN_IDLE;
         i_meta <= '1;
         ip     <= '1;
      end
      else
      begin
         v_meta <= vme_in;
         v      <= v_meta;
         i_meta <= ip_in;
         ip     <= i_meta;
      end
   end

   // ****************************************
   // Address decode
   // ****************************************
   logic [9:0] off;
   logic [9:0] io_idx;
   logic       am_sio;
   logic       am_std;
   logic       sio_hit;
   logic       mem_hit;
   logic [1:0] mem_slot;
   logic [3:0] mem_mask;
   logic [7:0] req;
   logic [2:0] winner;

   always_comb
   begin
      off     = {v.addr[9:1], 1'b0};
      io_idx  = off - carrier_pkg::IO_LO;
      am_sio  = (v.am == carrier_pkg::AM_SIO_USER) || (v.am == carrier_pkg::AM_SIO_SUP);
      am_std  = (v.am == carrier_pkg::AM_STD_USER) || (v.am == carrier_pkg::AM_STD_SUP);
      sio_hit = am_sio && (v.addr[15:10] == cfg.sio_base);
      mem_hit  = 1'b0;
      mem_slot = 2'h0;
      mem_mask = 4'h0;
      for (int s = carrier_pkg::NSLOT - 1; s >= 0; s--)
      begin
         if (((v.addr[23:20] ^ cfg.mem_base[s]) & ~size_mask(cfg.mem_size[s])) == 4'h0)
         begin
            mem_hit  = 1'b1;
            mem_slot = 2'(s);
            mem_mask = size_mask(cfg.mem_size[s]);
         end
      end
      req    = ~ip.intreq_n;
      winner = first_req(req);
   end

   // ****************************************
   // Carrier interrupt pending
   // ****************************************
   logic [7:0] req_q;
   logic       pending;
   logic       touch;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         req_q   <= 8'h00;
         pending <= 1'b0;
      end
      else
      begin
         req_q   <= req;
         pending <= (|(req & ~req_q)) | (pending & ~touch);
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         irq_oe <= 7'h00;
      else
      begin
         for (int k = 1; k <= 7; k++)
            irq_oe[k] <= pending && (cfg.irq_level == 3'(k));
      end
   end

   // ****************************************
   // Cycle sequencer
   // ****************************************
   state_t     state;
   logic [1:0] slot;
   logic       is_id;
   logic [3:0] led_kick;
   logic       bus_cycle;

   assign bus_cycle = !v.as_n && (v.ds_n != 2'b11);

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state    <= ST_IDLE;
         slot     <= 2'h0;
         is_id    <= 1'b0;
         touch    <= 1'b0;
         led_kick <= 4'h0;
         vme_out  <= carrier_pkg::VME_OUT_IDLE;
         ip_out   <= carrier_pkg::IP_OUT_IDLE;
      end
      else
      begin
         touch    <= 1'b0;
         led_kick <= 4'h0;
         unique case (state)
            ST_IDLE:
            begin
               if (bus_cycle)
               begin
                  ip_out.byte_n  <= v.ds_n;
                  ip_out.write_n <= v.write_n;
                  ip_out.wdata   <= v.data;
                  is_id          <= 1'b0;
                  if (!v.iack_n)
                  begin
                     if (!v.iackin_n)
                     begin
                        if (pending && (cfg.irq_level != 3'h0)
                            && (v.addr[3:1] == cfg.irq_level))
                        begin
                           slot <= winner[2:1];
                           ip_out.ip_interrupt_select_n[winner[2:1]] <= 1'b0;
                           ip_out.addr <= {21'h00000, winner[0]};
                           state <= ST_WAIT;
                        end
                        else
                        begin
                           vme_out.iackout_n <= 1'b0;
                           state <= ST_HOLD;
                        end
                     end
                  end
                  else if (sio_hit)
                  begin
                     if (off < carrier_pkg::IO_LO)
                     begin
                        touch <= (off == carrier_pkg::CLEAR_OFF);
                        vme_out.data <= (off == carrier_pkg::STATUS_OFF)
                                        ? {7'h00, pending, req} : 16'h0000;
                        vme_out.data_oe  <= v.write_n;
                        vme_out.dtack_oe <= 1'b1;
                        state <= ST_HOLD;
                     end
                     else if (off < carrier_pkg::ID_LO)
                     begin
                        slot <= io_idx[8:7];
                        ip_out.io_sel_n[io_idx[8:7]] <= 1'b0;
                        ip_out.addr <= {16'h0000, off[6:1]};
                        state <= ST_WAIT;
                     end
                     else
                     begin
                        slot  <= off[7:6];
                        is_id <= 1'b1;
                        ip_out.id_sel_n[off[7:6]] <= 1'b0;
                        ip_out.addr <= {17'h00000, off[5:1]};
                        state <= ST_WAIT;
                     end
                  end
                  else if (am_std && cfg.mem_enable && mem_hit)
                  begin
                     slot <= mem_slot;
                     ip_out.mem_sel_n[mem_slot] <= 1'b0;
                     ip_out.addr <= {v.addr[22:20] & mem_mask[2:0], v.addr[19:1]};
                     state <= ST_WAIT;
                  end
                  else
                     state <= ST_HOLD;
               end
            end
            ST_WAIT:
            begin
               if (v.as_n)
               begin
                  ip_out <= carrier_pkg::IP_OUT_IDLE;
                  state  <= ST_IDLE;
               end
               else if (!ip.ack_n[slot])
               begin
                  vme_out.data <= is_id ? {carrier_pkg::ID_UPPER, ip.rdata[7:0]}
                                        : ip.rdata;
                  vme_out.data_oe  <= ip_out.write_n;
                  vme_out.dtack_oe <= 1'b1;
                  led_kick[slot]   <= 1'b1;
                  ip_out <= carrier_pkg::IP_OUT_IDLE;
                  state  <= ST_HOLD;
               end
            end
            ST_HOLD:
            begin
               if (v.as_n && (v.ds_n == 2'b11))
               begin
                  vme_out <= carrier_pkg::VME_OUT_IDLE;
                  state   <= ST_IDLE;
               end
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // Activity stretchers
   // ****************************************
   logic [19:0] led_cnt [4];

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         led <= 4'h0;
         for (int s = 0; s < carrier_pkg::NSLOT; s++)
            led_cnt[s] <= 20'h00000;
      end
      else
      begin
         for (int s = 0; s < carrier_pkg::NSLOT; s++)
         begin
            if (led_kick[s])
               led_cnt[s] <= 20'(led_cycles);
            else if (led_cnt[s] != 20'h00000)
               led_cnt[s] <= led_cnt[s] - 20'h00001;
            led[s] <= led_kick[s] || (led_cnt[s] > 20'h00001);
         end
      end
   end

endmodule

// ==== test/carrier_props.sv ====
// Port checker for the carrier slave decode block.
// Assumes it is bound to the decode module; its ports mirror that module's ports.
module carrier_props #(
   parameter int unsigned led_cycles = 20
) (
   input wire logic              sys_clk,
   input wire logic              rst,
   input carrier_pkg::vme_in_t   vme_in,
   input carrier_pkg::vme_out_t  vme_out,
   input wire logic [7:1]        irq_oe,
   input carrier_pkg::ip_in_t    ip_in,
   input carrier_pkg::ip_out_t   ip_out,
   input carrier_pkg::cfg_t      cfg,
   input wire logic [3:0]        led
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // Helpers
   // ****************************************
   logic [15:0] sel_n;
   logic        dt;
   logic        sio;
   logic        std;
   logic        any_sel;
   logic        ack_any;
   int unsigned run;
   assign sel_n = {ip_out.io_sel_n, ip_out.id_sel_n, ip_out.mem_sel_n,
                   ip_out.ip_interrupt_select_n};
   assign dt = vme_out.dtack_oe;
   assign sio = vme_in.am == carrier_pkg::AM_SIO_USER || vme_in.am == carrier_pkg::AM_SIO_SUP;
   assign std = vme_in.am == carrier_pkg::AM_STD_USER || vme_in.am == carrier_pkg::AM_STD_SUP;
   assign any_sel = ~&sel_n;
   assign ack_any = ip_in.ack_n != 4'hf;
   // Length of the current lit run of slot 0
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         run <= 0;
      else
         run <= led[0] ? run + 1 : 0;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_bad_am; $rose(dt) && vme_in.iack_n |-> sio || std; endproperty
   a_bad_am: assert property (p_bad_am) else $error("dtack on foreign modifier");
   property p_mem_en; $rose(dt) && std |-> cfg.mem_enable; endproperty
   a_mem_en: assert property (p_mem_en) else $error("memory answered while off");
   property p_base; $rose(dt) && sio && vme_in.iack_n |-> vme_in.addr[15:10] == cfg.sio_base;
   endproperty
   a_base: assert property (p_base) else $error("short window base mismatch");
   property p_level; |irq_oe |-> irq_oe == 7'((8'h01 << cfg.irq_level) >> 1); endproperty
   a_level: assert property (p_level) else $error("request on wrong level");
   property p_one_sel; $onehot0(~sel_n); endproperty
   a_one_sel: assert property (p_one_sel) else $error("more than one select");
   property p_ack; $rose(dt) && $past(any_sel) |-> $past(ack_any, 2); endproperty
   a_ack: assert property (p_ack) else $error("dtack without slot ack");
   property p_led; $fell(led[0]) |-> run >= led_cycles; endproperty
   a_led: assert property (p_led) else $error("activity light too short");
   property p_chain; !vme_out.iackout_n |-> !dt; endproperty
   a_chain: assert property (p_chain) else $error("passed and answered at once");
   property p_lanes;
      $rose(any_sel) |-> ip_out.byte_n == vme_in.ds_n && ip_out.write_n == vme_in.write_n
                         && ip_out.wdata == vme_in.data;
   endproperty
   a_lanes: assert property (p_lanes) else $error("lanes not passed to slot");
   c_iack: cover property ($rose(dt) && !vme_in.iack_n);
   c_mem: cover property ($rose(dt) && std);
   c_led: cover property ($fell(led[0]));
endmodule

bind vme_ip_carrier_slave_decode carrier_props #(.led_cycles(led_cycles)) carrier_props_inst (
   .sys_clk(sys_clk), .rst(rst), .vme_in(vme_in), .vme_out(vme_out), .irq_oe(irq_oe),
   .ip_in(ip_in), .ip_out(ip_out), .cfg(cfg), .led(led));

// ==== test/ip_model.sv ====
// Behavioural IP slots: ack a select after a wait, return a tagged word.
// Assumes one select low at a time; request lines come from the bench.
module ip_model (
   input  wire logic             sys_clk,
   input  carrier_pkg::ip_out_t  ip_out,
   input  wire logic [7:0]       req_n,
   input  wire logic [3:0]       wait_cyc,
   output carrier_pkg::ip_in_t   ip_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // Slot responder
   // ****************************************
   logic [3:0]  ack_n = 4'hf;
   logic [15:0] rdata = 16'h0000;
   logic [3:0]  cnt = 4'h0;
   logic [3:0]  io, id, mem, vec, sel;
   logic [1:0]  kind, slot;
   assign {io, id, mem, vec} = ~{ip_out.io_sel_n, ip_out.id_sel_n, ip_out.mem_sel_n,
                                 ip_out.ip_interrupt_select_n};
   assign sel = io | id | mem | vec;
   assign slot = {sel[3] | sel[2], sel[3] | sel[1]};
   assign kind = {|(mem | vec), |(id | vec)};
   assign ip_in = '{ack_n: ack_n, intreq_n: req_n, rdata: rdata};
   always @(posedge sys_clk)
   begin
      if (sel == 4'h0)
      begin
         cnt <= 4'h0;
         ack_n <= 4'hf;
         // Released bus inverts its last word every cycle
         rdata <= ~rdata;
      end
      else if (cnt < wait_cyc)
         cnt <= cnt + 4'h1;
      else
      begin
         ack_n <= ~sel;
         rdata <= {4'ha, slot, kind, 3'h0,
                   (|vec) ? {4'h0, ip_out.addr[1]} : ip_out.addr[5:1]};
      end
   end
endmodule

// ==== test/vme_ip_carrier_slave_decode_tb.sv ====
// Self-checking bench for the carrier slave decode block.
// Assumes the IP slot model in ip_model and the bound port checker.
module vme_ip_carrier_slave_decode_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic                  sys_clk = 1'b0;
   logic                  rst = 1'b1;
   carrier_pkg::vme_in_t  vme_in = carrier_pkg::VME_IN_IDLE;
   carrier_pkg::vme_out_t vme_out, snap;
   carrier_pkg::ip_in_t   ip_in;
   carrier_pkg::ip_out_t  ip_out;
   carrier_pkg::cfg_t     cfg = '0;
   logic [7:1]            irq_oe;
   logic [3:0]            led;
   logic [7:0]            req_n = 8'hff;
   logic [3:0]            wait_cyc = 4'h0;
   int                    miscompares = 0;
   int                    checks = 0;
   always #50 sys_clk = ~sys_clk;
   vme_ip_carrier_slave_decode #(.led_cycles(20)) vme_ip_carrier_slave_decode_inst (
      .sys_clk(sys_clk), .rst(rst), .vme_in(vme_in), .vme_out(vme_out), .irq_oe(irq_oe),
      .ip_in(ip_in), .ip_out(ip_out), .cfg(cfg), .led(led));
   ip_model ip_model_inst (.sys_clk(sys_clk), .ip_out(ip_out), .req_n(req_n),
      .wait_cyc(wait_cyc), .ip_in(ip_in));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         miscompares++;
      end
   endtask
   task automatic print_verdict;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   function automatic logic [23:1] sio(input logic [9:0] off);
      return {8'h00, 6'h2a, off[9:1]};
   endfunction
   // Request line pattern for one level
   function automatic logic [15:0] irq_bits(input logic [2:0] lvl);
      return 16'h0001 << (lvl - 3'h1);
   endfunction
   // One bus cycle; ia low makes it an acknowledge cycle
   task automatic bus(input logic [5:0] am, input logic [23:1] a, input logic ia,
                      input logic rd, input logic ack, input logic [15:0] exp);
      int i;
      logic [1:0] ds;
      @(posedge sys_clk);
      // Word, even or odd byte; acknowledge cycles word or odd byte
      ds = ia ? 2'($urandom_range(2)) : {1'($urandom), 1'b0};
      vme_in <= '{addr: a, am: am, as_n: 1'b0, ds_n: ds, write_n: rd, iack_n: ia,
                  iackin_n: ia, data: 16'h5a5a};
      for (i = 0; i < 30 && vme_out.dtack_oe !== 1'b1; i++)
         @(posedge sys_clk);
      snap = vme_out;
      check(16'(vme_out.dtack_oe), 16'(ack));
      check(16'(vme_out.data_oe), 16'(ack & rd));
      if (ack && i == 30)
         print_verdict();
      if (ack && rd)
         check(vme_out.data, exp);
      vme_in <= carrier_pkg::VME_IN_IDLE;
      for (i = 0; i < 10 && (vme_out.dtack_oe !== 1'b0 || vme_out.iackout_n !== 1'b1); i++)
         @(posedge sys_clk);
      check(16'(i < 10), 16'h0001);
      if (i == 10)
         print_verdict();
      repeat (2) @(posedge sys_clk);
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      logic [4:0] r;
      logic [9:0] off;
      logic [5:0] am;
      logic [3:0] bs;
      logic [2:0] lvl;
      void'($urandom(32'h8420));
      lvl = 3'($urandom_range(7, 1));
      cfg.sio_base <= 6'h2a;
      cfg.irq_level <= lvl;
      cfg.mem_base <= {4'hb, 4'h8, 4'h5, 4'h2};
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      for (int s = 0; s < 4; s++)
         for (int k = 0; k < 2; k++)
         begin
            r = 5'($urandom);
            wait_cyc <= 4'($urandom_range(3));
            off = k ? 10'h300 + 10'(s * 64) + {4'h0, r, 1'b1}
                    : 10'h100 + 10'(s * 128) + {4'h0, r, 1'b0};
            bus(k ? carrier_pkg::AM_SIO_SUP : carrier_pkg::AM_SIO_USER, sio(off), 1, 1, 1,
                {k ? 8'hff : {4'ha, 2'(s), 2'(k)}, 3'h0, r});
            check(16'(led[s]), 16'h0001);
         end
      bus(carrier_pkg::AM_SIO_USER, sio(10'h2a4), 1, 0, 1, 16'h0000);
      bus(carrier_pkg::AM_SIO_USER, sio(10'h004), 1, 1, 1, 16'h0000);
      $display("test io_id done");
      bus(carrier_pkg::AM_STD_USER, {4'h5, 19'($urandom)}, 1, 1, 0, 16'h0000);
      cfg.mem_enable <= 1'b1;
      cfg.mem_size[0] <= 2'h1;
      for (int s = 0; s < 5; s++)
      begin
         r = 5'($urandom);
         bs = s < 4 ? cfg.mem_base[s] : 4'h3;
         bus(s[0] ? carrier_pkg::AM_STD_SUP : carrier_pkg::AM_STD_USER, {bs, 14'($urandom), r},
             1, 1, 1, {4'ha, 2'(s % 4), 2'h2, 3'h0, r});
      end
      $display("test memory done");
      for (int n = 0; n < 4; n++)
      begin
         am = 6'($urandom);
         if (am inside {6'h29, 6'h2d, 6'h39, 6'h3d})
            am = 6'h09;
         bus(am, sio(10'h104), 1, 1, 0, 16'h0000);
      end
      bus(carrier_pkg::AM_SIO_USER, {8'h00, 6'h15, 9'h080}, 1, 1, 0, 16'h0000);
      check(16'(led), 16'h0000);
      $display("test refusal done");
      req_n <= 8'hdb;
      repeat (6) @(posedge sys_clk);
      check(16'(irq_oe), irq_bits(lvl));
      bus(carrier_pkg::AM_SIO_SUP, sio(10'h000), 1, 1, 1, 16'h0124);
      bus(6'h29, {20'h00000, (lvl == 3'h7) ? 3'h1 : lvl + 3'h1}, 0, 1, 0, 16'h0000);
      check(16'(snap.iackout_n), 16'h0000);
      bus(6'h29, {20'h00000, lvl}, 0, 1, 1, 16'ha700);
      check(16'(irq_oe), irq_bits(lvl));
      bus(carrier_pkg::AM_SIO_USER, sio(10'h002), 1, 0, 1, 16'h0000);
      repeat (3) @(posedge sys_clk);
      check(16'(irq_oe), 16'h0000);
      req_n <= 8'hff;
      $display("test interrupt done");
      print_verdict();
   end
endmodule
